// File: ctd_calc_dma.sv
`timescale 1ns/1ns
// Notes on behaviour
// - trigger adds literal to operand, stores sum
// - counter decremented and written back each transfer
// - byte size steps operand pointer by one
// - halfword size steps operand pointer by two
// - zero counter flags zero event on trigger, no transfer
// - only priority level seven requests trigger
// - descriptor fetched from trigger vector address
// - literal mode uses source field as addend
// - mode word one-bit selects, multiple at 15
// - counter holds remaining transfers, exactly that many
module ctd_calc_dma
  import ctd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // trigger source
  input  wire logic        externalIrqLine,
  // memory master, simple request / acknowledge
  output logic             memReq,
  output logic             memWe,
  output logic [31:0]      memAddr,
  output logic [31:0]      memWdata,
  output logic [1:0]       memSize,
  input  wire logic [31:0] memRdata,
  input  wire logic        memAck,
  input  wire logic        memErr,
  // interrupt and state
  output logic             irq,
  output logic             busy
);

  // software state
  logic                  enable_q;      // engine enable
  logic [CTD_LVL_W-1:0]  level_q;       // priority level of the trigger source
  logic [31:0]           vector_q;      // vector entry: descriptor start
  logic [CTD_IRQ_W-1:0]  stat_q;        // sticky event bits
  logic [CTD_IRQ_W-1:0]  mask_q;        // interrupt mask
  logic [31:0]           doneCnt_q;     // completed transfers
  // engine state
  ctd_state_t            state_q;
  logic                  irqPrev_q;     // for rising edge detection
  logic                  pend_q;        // trigger waiting for engine
  logic [15:0]           mode_q;        // descriptor mode word
  logic [15:0]           count_q;       // descriptor transfer counter
  logic [31:0]           src_q;
  logic [31:0]           opr_q;
  logic [31:0]           dst_q;
  logic [31:0]           data_q;        // operand read from memory
  logic [31:0]           addend_q;      // first addend
  logic [31:0]           base_q;        // latched descriptor address

  // apb decode
  wire        apbAcc   = psel & penable;
  wire        apbWr    = apbAcc & pwrite;
  wire        hitCtrl  = (paddr == CTD_OFF_CTRL);
  wire        hitVect  = (paddr == CTD_OFF_VECT);
  wire        hitStat  = (paddr == CTD_OFF_STAT);
  wire        hitMask  = (paddr == CTD_OFF_MASK);
  wire        hitState = (paddr == CTD_OFF_STATE);
  wire        hitDone  = (paddr == CTD_OFF_DONE);
  wire        hitAny   = hitCtrl | hitVect | hitStat | hitMask | hitState | hitDone;

  // trigger qualification: a request only becomes a transfer at level seven
  wire        irqRise   = externalIrqLine & ~irqPrev_q;
  wire        levelOk   = (level_q == CTD_DMA_LEVEL);
  wire        trigger   = irqRise & enable_q & levelOk;

  // mode selects
  wire        isHalf    = mode_q[CTD_MOD_SIZE];
  wire        isImm     = mode_q[CTD_MOD_IMM];
  wire        updSrc    = mode_q[CTD_MOD_UPDS];
  wire        updDst    = mode_q[CTD_MOD_UPDD];
  wire        doCalc    = mode_q[CTD_MOD_OPER];
  wire        wantInt   = mode_q[CTD_MOD_INTE];
  wire [31:0] step      = isHalf ? CTD_STEP_HALF : CTD_STEP_BYTE;

  // truncate to transfer size, carry out of the top bit is lost
  function automatic logic [31:0] fit(input logic [31:0] v, input logic half);
    fit = half ? {16'h0000, v[15:0]} : {24'h000000, v[7:0]};
  endfunction

  wire [31:0] sumRaw    = fit(addend_q, isHalf) + fit(data_q, isHalf);
  wire [31:0] result    = doCalc ? fit(sumRaw, isHalf) : fit(addend_q, isHalf);
  wire [15:0] countDec  = count_q - CTD_CNT_ONE;
  wire        memDone   = memReq & memAck;
  // the last write of a transfer depends on which pointers step
  wire        lastWr    = (state_q == CTD_WRDST) || (state_q == CTD_WRSRC && !updDst)
                          || (state_q == CTD_WROPR && !updSrc && !updDst);
  wire [CTD_IRQ_W-1:0] evXfer = (memDone && lastWr && wantInt) ? 3'b001 : 3'b000;

  // register read mux
  logic [31:0] rdMux;
  always_comb begin
    rdMux = 32'h0000_0000;
    case (1'b1)
      hitCtrl:  rdMux = {28'h0000000, level_q, enable_q};
      hitVect:  rdMux = vector_q;
      hitStat:  rdMux = {29'h00000000, stat_q};
      hitMask:  rdMux = {29'h00000000, mask_q};
      hitState: rdMux = {count_q, 8'h00, pend_q, 3'h0, state_q};
      hitDone:  rdMux = doneCnt_q;
      default:  rdMux = 32'h0000_0000;
    endcase
  end

  // apb slave: zero wait states, error on unmapped addresses
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel & ~penable;
      pslverr <= psel & ~penable & ~hitAny;
      prdata  <= rdMux;
    end
  end

  // software registers; the write lands on the access edge while pready is high
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enable_q <= 1'b0;
      level_q  <= 3'h0;
      vector_q <= 32'h0000_0000;
      mask_q   <= 3'h0;
    end else if (apbWr & pready) begin
      if (hitCtrl) begin
        enable_q <= pwdata[CTD_CTRL_EN];
        level_q  <= pwdata[CTD_CTRL_LVL_LO +: CTD_LVL_W];
      end
      if (hitVect)
        vector_q <= pwdata;
      if (hitMask)
        mask_q   <= pwdata[CTD_IRQ_W-1:0];
    end
  end

  // event set wins over a write-one clear in the same cycle
  wire [CTD_IRQ_W-1:0] clrBits = (apbWr & pready & hitStat) ? pwdata[CTD_IRQ_W-1:0] : 3'h0;
  wire [CTD_IRQ_W-1:0] evZero  = (state_q == CTD_RDSRC && count_q == 16'h0000) ? 3'b010 : 3'b000;
  wire [CTD_IRQ_W-1:0] evErr   = (memReq & memErr) ? 3'b100 : 3'b000;
  wire [CTD_IRQ_W-1:0] evAll   = evXfer | evZero | evErr;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      stat_q <= 3'h0;
      irq    <= 1'b0;
    end else begin
      stat_q <= (stat_q & ~clrBits) | evAll;
      irq    <= |(((stat_q & ~clrBits) | evAll) & mask_q);
    end
  end

  // trigger latch: one pending request is held while the engine is working
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irqPrev_q <= 1'b0;
      pend_q    <= 1'b0;
    end else begin
      irqPrev_q <= externalIrqLine;
      if (trigger)
        pend_q <= 1'b1;
      else if (state_q == CTD_IDLE)
        pend_q <= 1'b0;
    end
  end

  // next memory request for each state
  logic        reqD;
  logic        weD;
  logic [31:0] addrD;
  logic [31:0] wdataD;
  always_comb begin
    reqD   = 1'b1;
    weD    = 1'b0;
    addrD  = 32'h0000_0000;
    wdataD = 32'h0000_0000;
    case (state_q)
      CTD_RDMOD:  addrD = base_q + CTD_DSC_MODCNT;
      CTD_RDSRC: begin
        // an exhausted descriptor must not leave a request without an answer
        reqD  = (count_q != 16'h0000);
        addrD = base_q + CTD_DSC_SRC;
      end
      CTD_RDOPR:  addrD = base_q + CTD_DSC_OPR;
      CTD_RDDST:  addrD = base_q + CTD_DSC_DST;
      CTD_RDSMEM: addrD = src_q;
      CTD_RDDAT:  addrD = opr_q;
      CTD_WRRES: begin
        weD = 1'b1; addrD = dst_q; wdataD = result;
      end
      CTD_WRCNT: begin
        weD = 1'b1; addrD = base_q + CTD_DSC_MODCNT; wdataD = {countDec, mode_q};
      end
      CTD_WROPR: begin
        weD = 1'b1; addrD = base_q + CTD_DSC_OPR; wdataD = opr_q + step;
      end
      CTD_WRSRC: begin
        weD = 1'b1; addrD = base_q + CTD_DSC_SRC; wdataD = src_q + step;
      end
      CTD_WRDST: begin
        weD = 1'b1; addrD = base_q + CTD_DSC_DST; wdataD = dst_q + step;
      end
      default: reqD = 1'b0;
    endcase
  end

  // memory port registers
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      memReq   <= 1'b0;
      memWe    <= 1'b0;
      memAddr  <= 32'h0000_0000;
      memWdata <= 32'h0000_0000;
      memSize  <= 2'h0;
      busy     <= 1'b0;
    end else begin
      memReq   <= reqD & ~memDone & ~memErr;
      memWe    <= weD;
      memAddr  <= addrD;
      memWdata <= wdataD;
      memSize  <= (state_q == CTD_WRRES || state_q == CTD_RDDAT || state_q == CTD_RDSMEM)
                  ? {isHalf, ~isHalf} : 2'h3;
      busy     <= (state_q != CTD_IDLE);
    end
  end

  // engine sequence: one transfer per accepted trigger
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_q   <= CTD_IDLE;
      base_q    <= 32'h0000_0000;
      mode_q    <= 16'h0000;
      count_q   <= 16'h0000;
      src_q     <= 32'h0000_0000;
      opr_q     <= 32'h0000_0000;
      dst_q     <= 32'h0000_0000;
      data_q    <= 32'h0000_0000;
      addend_q  <= 32'h0000_0000;
      doneCnt_q <= 32'h0000_0000;
    end else if (memReq & memErr) begin
      state_q <= CTD_IDLE;                    // bus error abandons the transfer
    end else begin
      case (state_q)
        CTD_IDLE: if (pend_q) begin
          base_q  <= vector_q;
          state_q <= CTD_RDMOD;
        end
        CTD_RDMOD: if (memDone) begin
          mode_q  <= memRdata[15:0];
          count_q <= memRdata[31:16];
          state_q <= CTD_RDSRC;
        end
        CTD_RDSRC: if (count_q == 16'h0000) begin
          state_q <= CTD_IDLE;                 // exhausted descriptor: no transfer
        end else if (memDone) begin
          src_q   <= memRdata;
          state_q <= CTD_RDOPR;
        end
        CTD_RDOPR: if (memDone) begin
          opr_q   <= memRdata;
          state_q <= CTD_RDDST;
        end
        CTD_RDDST: if (memDone) begin
          dst_q    <= memRdata;
          addend_q <= src_q;
          state_q  <= isImm ? (doCalc ? CTD_RDDAT : CTD_WRRES) : CTD_RDSMEM;
        end
        CTD_RDSMEM: if (memDone) begin
          addend_q <= memRdata;                // source field is an address here
          state_q  <= doCalc ? CTD_RDDAT : CTD_WRRES;
        end
        CTD_RDDAT: if (memDone) begin
          data_q  <= memRdata;
          state_q <= CTD_WRRES;
        end
        CTD_WRRES: if (memDone) state_q <= CTD_WRCNT;
        CTD_WRCNT: if (memDone) begin
          count_q <= countDec;
          state_q <= CTD_WROPR;
        end
        CTD_WROPR: if (memDone) begin
          opr_q     <= opr_q + step;
          doneCnt_q <= doneCnt_q + 32'h0000_0001;
          state_q   <= updSrc ? CTD_WRSRC : (updDst ? CTD_WRDST : CTD_IDLE);
        end
        CTD_WRSRC: if (memDone) state_q <= updDst ? CTD_WRDST : CTD_IDLE;
        CTD_WRDST: if (memDone) state_q <= CTD_IDLE;
        default: state_q <= CTD_IDLE;
      endcase
    end
  end

endmodule

// File: ctd_pkg.sv
package ctd_pkg;
  // apb register byte offsets
  localparam logic [7:0] CTD_OFF_CTRL   = 8'h00;
  localparam logic [7:0] CTD_OFF_VECT   = 8'h04;
  localparam logic [7:0] CTD_OFF_STAT   = 8'h08;
  localparam logic [7:0] CTD_OFF_MASK   = 8'h0C;
  localparam logic [7:0] CTD_OFF_STATE  = 8'h10;
  localparam logic [7:0] CTD_OFF_DONE   = 8'h14;
  // control fields
  localparam int CTD_CTRL_EN      = 0;
  localparam int CTD_CTRL_LVL_LO  = 1;
  localparam int CTD_LVL_W        = 3;
  localparam logic [2:0] CTD_DMA_LEVEL = 3'h7;
  // mode word bit positions
  localparam int CTD_MOD_SIZE  = 0;
  localparam int CTD_MOD_IMM   = 1;
  localparam int CTD_MOD_UPDS  = 2;
  localparam int CTD_MOD_UPDD  = 3;
  localparam int CTD_MOD_OPER  = 4;
  localparam int CTD_MOD_BRST  = 5;
  localparam int CTD_MOD_INTE  = 6;
  localparam int CTD_MOD_CHAIN = 7;
  localparam int CTD_MOD_MULT  = 15;
  // descriptor word offsets (bytes from descriptor start)
  localparam logic [31:0] CTD_DSC_MODCNT = 32'h0000_0000;
  localparam logic [31:0] CTD_DSC_SRC    = 32'h0000_0004;
  localparam logic [31:0] CTD_DSC_OPR    = 32'h0000_0008;
  localparam logic [31:0] CTD_DSC_DST    = 32'h0000_000C;
  // interrupt status bits
  localparam int CTD_IRQ_XFER = 0;
  localparam int CTD_IRQ_ZERO = 1;
  localparam int CTD_IRQ_ERR  = 2;
  localparam int CTD_IRQ_W    = 3;
  // pointer steps
  localparam logic [31:0] CTD_STEP_BYTE = 32'h0000_0001;
  localparam logic [31:0] CTD_STEP_HALF = 32'h0000_0002;
  localparam logic [15:0] CTD_CNT_ONE   = 16'h0001;
  // engine states
  typedef enum logic [3:0] {
    CTD_IDLE   = 4'b0000,
    CTD_RDMOD  = 4'b0001,
    CTD_RDSRC  = 4'b0010,
    CTD_RDOPR  = 4'b0011,
    CTD_RDDST  = 4'b0100,
    CTD_RDDAT  = 4'b0101,
    CTD_RDSMEM = 4'b0110,
    CTD_WRRES  = 4'b0111,
    CTD_WRCNT  = 4'b1000,
    CTD_WROPR  = 4'b1001,
    CTD_WRSRC  = 4'b1010,
    CTD_WRDST  = 4'b1011
  } ctd_state_t;
endpackage

// File: ctd_calc_dma_checker.sv
`timescale 1ns/1ns
// pin-level watcher for the calculation dma engine
module ctd_calc_dma_checker
  import ctd_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        rst,
  // apb side
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  // memory side
  input wire logic        memReq,
  input wire logic        memWe,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  input wire logic [1:0]  memSize,
  input wire logic        memAck,
  input wire logic        memErr,
  input wire logic        busy
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access phase");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready held");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_req_holds: assert property (memReq && !memAck && !memErr |=> memReq &&
    $stable(memAddr) && $stable(memWe) && $stable(memWdata)) else $error("request moved");
  a_req_drops: assert property (memReq && (memAck || memErr) |=> !memReq)
    else $error("request kept after answer");
  a_byte_sum: assert property (memReq && memWe && memSize == 2'h1 |->
    memWdata[31:8] == 24'h0) else $error("byte result not truncated");
  a_half_sum: assert property (memReq && memWe && memSize == 2'h2 |->
    memWdata[31:16] == 16'h0) else $error("half result not truncated");
  a_fetch_first: assert property ($rose(memReq) && !$past(busy) |-> !memWe)
    else $error("transfer did not start with a fetch");
endmodule
bind ctd_calc_dma ctd_calc_dma_checker chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pready(pready), .pslverr(pslverr), .memReq(memReq), .memWe(memWe),
  .memAddr(memAddr), .memWdata(memWdata), .memSize(memSize), .memAck(memAck),
  .memErr(memErr), .busy(busy));

// File: ctd_mem_model.sv
`timescale 1ns/1ns
// byte-addressed little-endian memory answering the engine
module ctd_mem_model (
  // clock
  input  wire logic        clk,
  // engine requests
  input  wire logic        memReq,
  input  wire logic        memWe,
  input  wire logic [31:0] memAddr,
  input  wire logic [31:0] memWdata,
  input  wire logic [1:0]  memSize,
  // answers
  output logic [31:0]      memRdata,
  output logic             memAck,
  output logic             memErr,
  // bench controls: idle cycles before answering, fault injection
  input  wire logic [1:0]  lag,
  input  wire logic        failNext
);
  logic [7:0]  mem [0:8191]; // descriptor, operands and results live here
  logic [1:0]  waitCnt;      // cycles already stalled
  logic [12:0] a;            // byte address inside the array
  logic [31:0] word;         // word starting at a
  assign a = memAddr[12:0];
  assign word = {mem[a+13'd3], mem[a+13'd2], mem[a+13'd1], mem[a]};
  initial begin
    memAck = 1'b0;
    memErr = 1'b0;
    memRdata = 32'h0;
    waitCnt = 2'h0;
  end
  // read data lives only in the answer cycle, ack or error; otherwise it toggles so stale data is caught
  always @(posedge clk) begin
    memAck <= 1'b0;
    memErr <= 1'b0;
    memRdata <= ~memRdata;
    if (memReq && !memAck && !memErr) begin
      if (waitCnt < lag) begin
        waitCnt <= waitCnt + 2'd1;
      end else begin
        waitCnt <= 2'd0;
        memErr <= failNext;
        memAck <= !failNext;
        if (memWe && !failNext) begin
          for (int i = 0; i < 4; i++) begin
            if (i < ((memSize == 2'h3) ? 4 : int'(memSize))) mem[a+13'(i)] <= memWdata[8*i+:8];
          end
        end else begin
          // narrow reads repeated on every lane, so any lane choice gets the operand
          memRdata <= (memSize == 2'h1) ? {4{word[7:0]}} :
                      (memSize == 2'h2) ? {2{word[15:0]}} : word;
        end
      end
    end
  end
endmodule

// File: ctd_calc_dma_tb_top.sv
`timescale 1ns/1ns
// self-checking bench: apb traffic and triggered calculation transfers
module ctd_calc_dma_tb_top;
  import ctd_pkg::*;
  logic        clk, rst, psel, penable, pwrite, pready, pslverr, externalIrqLine;
  logic        memReq, memWe, memAck, memErr, irq, busy, failNext;
  logic [7:0]  paddr, ev, pre;
  logic [31:0] pwdata, prdata, memAddr, memWdata, memRdata, rnd;
  logic [1:0]  memSize, lag;
  logic [32:0] expQ [$]; // expected {error, data} of pending reads
  int          bad_count, checked, i;
  ctd_calc_dma dut (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .externalIrqLine(externalIrqLine), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memSize(memSize), .memRdata(memRdata), .memAck(memAck),
    .memErr(memErr), .irq(irq), .busy(busy));
  ctd_mem_model far (.clk(clk), .memReq(memReq), .memWe(memWe), .memAddr(memAddr),
    .memWdata(memWdata), .memSize(memSize), .memRdata(memRdata), .memAck(memAck),
    .memErr(memErr), .lag(lag), .failNext(failNext));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction
  function automatic logic [31:0] get32(input int a);
    return {far.mem[a+3], far.mem[a+2], far.mem[a+1], far.mem[a]};
  endfunction
  task automatic put32(input int a, input logic [31:0] v);
    for (int k = 0; k < 4; k++) far.mem[a+k] = v[8*k+:8];
  endtask
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer; a read notes its expected answer first
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic e);
    if (!w) expQ.push_back({e, d});
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // read checker: takes the oldest note when a read completes
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) chk({pslverr, prdata}, expQ.pop_front());
  end
  // one trigger edge, random memory lag, then wait for the engine to go idle
  task automatic fire();
    rnd = xs(rnd);
    lag <= rnd[1:0];
    externalIrqLine <= 1'b1;
    @(posedge clk);
    externalIrqLine <= 1'b0;
    for (int n = 0; n < 10 && busy !== 1'b1; n++) @(posedge clk);
    while (busy !== 1'b0) @(posedge clk);
  endtask
  task automatic dsc(input logic [15:0] c, input logic [15:0] m, input logic [31:0] o);
    put32(256, {c, m});
    put32(260, 32'h20);
    put32(264, o);
    put32(268, 32'h1000);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial begin
    {rst, psel, penable, pwrite, externalIrqLine, failNext} = 6'h20;
    {paddr, pwdata, lag, bad_count, checked} = '0;
    rnd = 32'hf7bf;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    apb(0, CTD_OFF_CTRL, 0, 0);
    apb(0, CTD_OFF_MASK, 0, 0);
    apb(0, 8'h18, 0, 1);
    apb(1, CTD_OFF_MASK, 7, 0);
    apb(1, CTD_OFF_VECT, 256, 0);
    apb(1, CTD_OFF_CTRL, 32'hF, 0);
    for (i = 0; i < 5; i++) begin
      rnd = xs(rnd);
      far.mem[1024+i] = rnd[7:0];
    end
    far.mem[1026] = 8'hFF;
    dsc(5, 16'h0012, 32'h400);
    for (i = 0; i < 6; i++) begin
      ev = far.mem[1024+i] + 8'h20;
      pre = far.mem[4096];
      fire();
      chk(33'(far.mem[4096]), 33'(i < 5 ? ev : pre));
      chk(33'(get32(256)), {1'b0, i < 5 ? 16'(4 - i) : 16'h0, 16'h0012});
      chk(33'(get32(264)), 33'(1025 + (i < 5 ? i : 4)));
    end
    apb(0, CTD_OFF_STAT, 2, 0);
    chk(33'(irq), 33'(1));
    apb(1, CTD_OFF_MASK, 0, 0);
    @(posedge clk);
    chk(33'(irq), 33'(0));
    apb(1, CTD_OFF_MASK, 7, 0);
    apb(1, CTD_OFF_STAT, 2, 0);
    @(posedge clk);
    chk(33'(irq), 33'(0));
    put32(1280, 32'hFFF0);
    dsc(2, 16'h005B, 32'h500); // half, literal, calc, dest stepping, done interrupt
    apb(1, CTD_OFF_CTRL, 32'hD, 0);
    fire();
    chk(33'(get32(256)), 33'(32'h0002_005B));
    apb(1, CTD_OFF_CTRL, 32'hF, 0);
    fire();
    chk(33'(get32(4096) & 32'hFFFF), 33'(32'h10));
    chk(33'(get32(264)), 33'(32'h502));
    chk(33'(get32(268)), 33'(32'h1002));
    failNext <= 1'b1;
    fire();
    failNext <= 1'b0;
    apb(0, CTD_OFF_STAT, 5, 0);
    apb(0, CTD_OFF_DONE, 6, 0);
    apb(0, CTD_OFF_STATE, 32'h0001_0000, 0);
    final_report();
  end
endmodule
